// ==== hw/rxt_ctrl.sv ====
// receive-timeout control: config register, RC-period counter, early exit
`timescale 1ns/100ps
module rxt_ctrl
(
  input  wire logic                              SYS_CLK,
  input  wire logic                              RESETN,
  input  wire logic                              CFG_WE,
  input  wire logic [7:0]                        CFG_WDATA,
  output logic      [7:0]                        CFG_RDATA,
  input  wire logic [rxt_pkg::EVENT_WIDTH-1:0]   WAKE_EVENT_PERIOD,
  input  wire logic [1:0]                        WOR_RES,
  input  wire logic                              RC_OSC_CLK,
  input  wire logic                              RX_ACTIVE,
  input  wire logic                              RX_START,
  input  wire logic                              PACKET_END,
  input  wire logic                              SYMBOL_TICK,
  input  wire logic                              ASK_OOK_MODE,
  input  wire logic                              CARRIER_SENSE,
  input  wire logic                              RSSI_ABOVE_THRESH,
  input  wire logic                              SYNC_FOUND,
  input  wire logic                              PREAMBLE_QUALITY_INDICATOR,
  output logic                                   RX_TERMINATE,
  output logic                                   TIMEOUT_RUNNING
);
  import rxt_pkg::*;

  typedef struct packed {
    logic [CFG_WIDTH-1:0]   cfg;
    logic [7:0]             rdata;
    rxt_state_t             state;
    logic [LIMIT_WIDTH-1:0] count;
    logic [3:0]             sym_cnt;
    logic                   cs_seen;
    logic                   term;
    logic                   run;
  } rxt_ctrl_t;

  rxt_ctrl_t st;
  rxt_ctrl_t next_st;

  // ****************************************
  // timeout limit
  // ****************************************
  logic                       rc_tick;
  logic [2:0]                 rx_time;
  logic                       carrier_sense_early_exit;
  logic                       timeout_quality_check_select;
  logic [EVENT_USED_BITS-1:0] ev_used;
  logic [3:0]                 res_scale;
  logic [LIMIT_WIDTH-1:0]     limit;
  logic                       cs_src;
  logic                       cs_fail;
  logic                       expire;
  logic                       keep_ok;

  rxt_sync u_rc_sync
  (
    .clk      (SYS_CLK),
    .resetn   (RESETN),
    .async_in (RC_OSC_CLK),
    .rise     (rc_tick)
  );

  assign rx_time                      = st.cfg[CFG_TIME_MSB:CFG_TIME_LSB];
  assign carrier_sense_early_exit     = st.cfg[CFG_CS_EXIT_BIT];
  assign timeout_quality_check_select = st.cfg[CFG_QUAL_BIT];
  assign ev_used = WAKE_EVENT_PERIOD[EVENT_USED_LSB +: EVENT_USED_BITS];

  always_comb
  begin
    case (WOR_RES)
      2'h0:    res_scale = RES_SCALE_0;
      2'h1:    res_scale = RES_SCALE_1;
      2'h2:    res_scale = RES_SCALE_2;
      default: res_scale = RES_SCALE_3;
    endcase
  end

  // period scaled by resolution, halved per selection step
  assign limit = LIMIT_WIDTH'({4'h0, ev_used} * {13'h0, res_scale}) >> rx_time;

  assign cs_src  = ASK_OOK_MODE ? RSSI_ABOVE_THRESH : CARRIER_SENSE;
  assign expire  = (st.state == ST_RUN) && rc_tick && (st.count <= LIMIT_WIDTH'(1));
  assign cs_fail = (st.state == ST_RUN) && carrier_sense_early_exit && !st.cs_seen && !cs_src
                   && SYMBOL_TICK && (st.sym_cnt == SYMBOLS_CS - 4'h1);
  assign keep_ok = SYNC_FOUND || (timeout_quality_check_select && PREAMBLE_QUALITY_INDICATOR);

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    next_st      = st;
    next_st.term = 1'b0;
    if (CFG_WE)
      next_st.cfg = CFG_WDATA[CFG_WIDTH-1:0];
    next_st.rdata = {3'h0, next_st.cfg};
    case (st.state)
      ST_IDLE:
      begin
        if (RX_ACTIVE && RX_START)
        begin
          next_st.sym_cnt = 4'h0;
          next_st.cs_seen = 1'b0;
          next_st.count   = limit;
          if (rx_time == RX_TIME_NONE)
            next_st.state = ST_KEEP;
          else
            next_st.state = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (rc_tick)
          next_st.count = st.count - LIMIT_WIDTH'(1);
        if (SYMBOL_TICK && st.sym_cnt < SYMBOLS_CS)
          next_st.sym_cnt = st.sym_cnt + 4'h1;
        if (cs_src && st.sym_cnt < SYMBOLS_CS)
          next_st.cs_seen = 1'b1;
        if (!RX_ACTIVE || PACKET_END)
          next_st.state = ST_IDLE;
        else if (cs_fail)
        begin
          next_st.state = ST_IDLE;
          next_st.term  = 1'b1;
        end
        else if (expire)
        begin
          if (keep_ok)
            next_st.state = ST_KEEP;
          else
          begin
            next_st.state = ST_IDLE;
            next_st.term  = 1'b1;
          end
        end
      end
      ST_KEEP:
      begin
        if (!RX_ACTIVE || PACKET_END)
          next_st.state = ST_IDLE;
      end
      default:
        next_st.state = ST_IDLE;
    endcase
    next_st.run = (next_st.state == ST_RUN);
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RESETN)
    begin
      st       <= '0;
      st.cfg   <= CFG_RESET[CFG_WIDTH-1:0];
      st.rdata <= CFG_RESET;
      st.state <= ST_IDLE;
    end
    else
      st <= next_st;
  end

  assign CFG_RDATA       = st.rdata;
  assign RX_TERMINATE    = st.term;
  assign TIMEOUT_RUNNING = st.run;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);

  property p_no_timeout;
    (st.state == ST_IDLE) && RX_ACTIVE && RX_START && (rx_time == RX_TIME_NONE)
      |=> (st.state == ST_KEEP) && !TIMEOUT_RUNNING;
  endproperty
  a_no_timeout: assert property (p_no_timeout) else $error("selection 7 did not disable timeout");

  property p_load;
    (st.state == ST_IDLE) && RX_ACTIVE && RX_START && (rx_time != RX_TIME_NONE)
      |=> TIMEOUT_RUNNING && (st.count == $past(limit));
  endproperty
  a_load: assert property (p_load) else $error("timeout limit not loaded");

  property p_ev_bits;
    $stable(WAKE_EVENT_PERIOD[EVENT_USED_LSB +: EVENT_USED_BITS]) && $stable(WOR_RES) && $stable(rx_time)
      |-> $stable(limit);
  endproperty
  a_ev_bits: assert property (p_ev_bits) else $error("limit depends on low event bits");

  property p_cs_exit;
    cs_fail |=> RX_TERMINATE && (st.state == ST_IDLE);
  endproperty
  a_cs_exit: assert property (p_cs_exit) else $error("carrier-sense early exit missed");

  property p_qual_keep;
    expire && !cs_fail && RX_ACTIVE && !PACKET_END && keep_ok |=> !RX_TERMINATE && (st.state == ST_KEEP);
  endproperty
  a_qual_keep: assert property (p_qual_keep) else $error("receive ended despite sync or quality");

  property p_term_cause;
    $rose(RX_TERMINATE) |-> $past(cs_fail || (expire && !keep_ok));
  endproperty
  a_term_cause: assert property (p_term_cause) else $error("terminate without a cause");

  property p_count_step;
    (st.state == ST_RUN) && rc_tick && !expire && !cs_fail && RX_ACTIVE && !PACKET_END
      |=> (st.count == $past(st.count) - LIMIT_WIDTH'(1));
  endproperty
  a_count_step: assert property (p_count_step) else $error("timeout count did not step on an RC tick");

  property p_keep_quiet;
    (st.state == ST_KEEP) |=> !RX_TERMINATE && !TIMEOUT_RUNNING;
  endproperty
  a_keep_quiet: assert property (p_keep_quiet) else $error("terminate or count while receiving to packet end");

  property p_abort;
    (st.state != ST_IDLE) && (!RX_ACTIVE || PACKET_END) |=> (st.state == ST_IDLE) && !RX_TERMINATE;
  endproperty
  a_abort: assert property (p_abort) else $error("packet end or receive loss not honoured");

  c_expire_end: cover property (expire && !keep_ok ##1 RX_TERMINATE);
  c_expire_keep: cover property (expire && keep_ok ##1 st.state == ST_KEEP);
  c_cs_exit: cover property (cs_fail ##1 RX_TERMINATE);
  c_no_timeout: cover property (RX_START && rx_time == RX_TIME_NONE ##1 st.state == ST_KEEP);
  c_keep_end: cover property ((st.state == ST_KEEP) && PACKET_END ##1 st.state == ST_IDLE);

endmodule // rxt_ctrl

// ==== hw/rxt_pkg.sv ====
// constants and types for the receive-timeout control block
//
// What this block does
// - The receive timeout is the wake event period times a constant set by timeout selection and wake resolution, times 26, over the crystal frequency.
// - With the carrier-sense early-exit bit set, receive ends early when no carrier sense (signal strength in ASK/OOK) appears in the first 8 symbols.
// - At timeout the block keeps receiving if a sync word was found, or, with the quality-check select bit set, if the preamble quality indicator is set.
// - The timeout period comes from the 13 upper bits of the wake event period and works in polled and normal receive alike.
package rxt_pkg;

  // ****************************************
  // register layout
  // ****************************************
  localparam logic [7:0] CFG_RESET       = 8'h07;
  localparam int         CFG_CS_EXIT_BIT = 4;
  localparam int         CFG_QUAL_BIT    = 3;
  localparam int         CFG_TIME_MSB    = 2;
  localparam int         CFG_TIME_LSB    = 0;
  localparam int         CFG_WIDTH       = 5;
  localparam logic [2:0] RX_TIME_NONE    = 3'h7;

  // ****************************************
  // timing
  // ****************************************
  localparam int         EVENT_WIDTH     = 16;
  localparam int         EVENT_USED_LSB  = 3;
  localparam int         EVENT_USED_BITS = 13;
  localparam int         LIMIT_WIDTH     = 17;
  localparam logic [3:0] SYMBOLS_CS      = 4'h8;

  // wake resolution scale, ratio of the constants across resolutions 0..3
  localparam logic [3:0] RES_SCALE_0     = 4'h1;
  localparam logic [3:0] RES_SCALE_1     = 4'h5;
  localparam logic [3:0] RES_SCALE_2     = 4'h9;
  localparam logic [3:0] RES_SCALE_3     = 4'hd;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_KEEP = 2'b10
  } rxt_state_t;

endpackage

// ==== hw/rxt_sync.sv ====
// two-stage synchroniser with rising-edge pulse for the RC oscillator clock
`timescale 1ns/100ps
module rxt_sync
(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic async_in,
  output logic      rise
);

  typedef struct packed {
    logic meta;
    logic stable;
    logic last;
    logic rise;
  } rxt_sync_t;

  rxt_sync_t st;
  rxt_sync_t next_st;

  always_comb
  begin
    next_st        = st;
    next_st.meta   = async_in;
    next_st.stable = st.meta;
    next_st.last   = st.stable;
    next_st.rise   = st.stable & ~st.last;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign rise = st.rise;

endmodule // rxt_sync

// ==== test/tb_rx_timeout_control.sv ====
// self-checking bench for the receive-timeout control block
`timescale 1ns/100ps
module tb_rx_timeout_control;
  import rxt_pkg::*;
  logic        SYS_CLK, RESETN, CFG_WE, RC_OSC_CLK, RX_ACTIVE, RX_START, PACKET_END, SYMBOL_TICK;
  logic        ASK_OOK_MODE, CARRIER_SENSE, RSSI_ABOVE_THRESH, SYNC_FOUND, PREAMBLE_QUALITY_INDICATOR;
  logic        RX_TERMINATE, TIMEOUT_RUNNING;
  logic [7:0]  CFG_WDATA, CFG_RDATA;
  logic [15:0] WAKE_EVENT_PERIOD;
  logic [1:0]  WOR_RES;
  int          mismatches;
  int          samples_checked;

  rxt_ctrl dut
  (
    .SYS_CLK                    (SYS_CLK),
    .RESETN                     (RESETN),
    .CFG_WE                     (CFG_WE),
    .CFG_WDATA                  (CFG_WDATA),
    .CFG_RDATA                  (CFG_RDATA),
    .WAKE_EVENT_PERIOD          (WAKE_EVENT_PERIOD),
    .WOR_RES                    (WOR_RES),
    .RC_OSC_CLK                 (RC_OSC_CLK),
    .RX_ACTIVE                  (RX_ACTIVE),
    .RX_START                   (RX_START),
    .PACKET_END                 (PACKET_END),
    .SYMBOL_TICK                (SYMBOL_TICK),
    .ASK_OOK_MODE               (ASK_OOK_MODE),
    .CARRIER_SENSE              (CARRIER_SENSE),
    .RSSI_ABOVE_THRESH          (RSSI_ABOVE_THRESH),
    .SYNC_FOUND                 (SYNC_FOUND),
    .PREAMBLE_QUALITY_INDICATOR (PREAMBLE_QUALITY_INDICATOR),
    .RX_TERMINATE               (RX_TERMINATE),
    .TIMEOUT_RUNNING            (TIMEOUT_RUNNING)
  );

  // ****************************************
  // helpers
  // ****************************************
  task check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_of_test;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task wr(input logic [7:0] d);
    @(posedge SYS_CLK) CFG_WE <= 1'b1;
    CFG_WDATA <= d;
    @(posedge SYS_CLK) CFG_WE <= 1'b0;
    @(posedge SYS_CLK) #1;
    check(CFG_RDATA, {3'h0, d[4:0]});
  endtask

  task start;
    @(posedge SYS_CLK) RX_ACTIVE <= 1'b1;
    RX_START <= 1'b1;
    @(posedge SYS_CLK) RX_START <= 1'b0;
    @(posedge SYS_CLK) #1;
  endtask

  task idle;
    @(posedge SYS_CLK) PACKET_END <= 1'b1;
    RX_ACTIVE <= 1'b0;
    @(posedge SYS_CLK) PACKET_END <= 1'b0;
    @(posedge SYS_CLK);
  endtask

  // window in which a terminate pulse may or may not appear
  task wait_term(input int n, output logic seen);
    seen = 1'b0;
    repeat (n)
    begin
      @(posedge SYS_CLK) #1;
      if (RX_TERMINATE === 1'b1)
        seen = 1'b1;
    end
  endtask

  task rc_tick;
    @(posedge SYS_CLK) RC_OSC_CLK <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    RC_OSC_CLK <= 1'b0;
    repeat (4) @(posedge SYS_CLK);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task run_to(input logic [7:0] cfg, input logic [15:0] ev, input logic [1:0] res, input int ticks,
              input logic sync, input logic preamble_quality_indicator, input logic term);
    logic seen;
    wr(cfg);
    @(posedge SYS_CLK) WAKE_EVENT_PERIOD <= ev;
    WOR_RES <= res;
    SYNC_FOUND <= sync;
    PREAMBLE_QUALITY_INDICATOR <= preamble_quality_indicator;
    start;
    check({7'h0, TIMEOUT_RUNNING}, 8'h01);
    repeat (ticks - 1) rc_tick;
    #1;
    check({7'h0, TIMEOUT_RUNNING}, 8'h01);
    @(posedge SYS_CLK) RC_OSC_CLK <= 1'b1;
    wait_term(12, seen);
    @(posedge SYS_CLK) RC_OSC_CLK <= 1'b0;
    #1;
    check({7'h0, seen}, {7'h0, term});
    check({7'h0, TIMEOUT_RUNNING}, 8'h00);
    idle;
  endtask

  task early(input logic ask, input logic cs, input logic rssi, input logic term);
    logic seen;
    wr(8'h10);
    @(posedge SYS_CLK) ASK_OOK_MODE <= ask;
    CARRIER_SENSE <= cs;
    RSSI_ABOVE_THRESH <= rssi;
    start;
    check({7'h0, TIMEOUT_RUNNING}, 8'h01);
    repeat (7)
    begin
      @(posedge SYS_CLK) SYMBOL_TICK <= 1'b1;
      @(posedge SYS_CLK) SYMBOL_TICK <= 1'b0;
    end
    wait_term(3, seen);
    check({7'h0, seen}, 8'h00);
    check({7'h0, TIMEOUT_RUNNING}, 8'h01);
    @(posedge SYS_CLK) SYMBOL_TICK <= 1'b1;
    @(posedge SYS_CLK) SYMBOL_TICK <= 1'b0;
    #1;
    check({7'h0, RX_TERMINATE}, {7'h0, term});
    check({7'h0, TIMEOUT_RUNNING}, {7'h0, ~term});
    wait_term(3, seen);
    check({7'h0, seen}, 8'h00);
    idle;
  endtask

  // selection 7: no limit, receive stays up through RC ticks
  task no_limit;
    logic seen;
    wr(8'h07);
    start;
    check({7'h0, TIMEOUT_RUNNING}, 8'h00);
    rc_tick;
    rc_tick;
    wait_term(12, seen);
    check({7'h0, seen}, 8'h00);
    check({7'h0, TIMEOUT_RUNNING}, 8'h00);
    idle;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    SYS_CLK = 1'b0;
    forever #4 SYS_CLK = ~SYS_CLK;
  end

  initial
  begin
    mismatches = 0;
    samples_checked = 0;
    {RESETN, CFG_WE, RC_OSC_CLK, RX_ACTIVE, RX_START, PACKET_END, SYMBOL_TICK} = '0;
    {ASK_OOK_MODE, CARRIER_SENSE, RSSI_ABOVE_THRESH, SYNC_FOUND, PREAMBLE_QUALITY_INDICATOR} = '0;
    CFG_WDATA = 8'h00;
    WAKE_EVENT_PERIOD = 16'h0000;
    WOR_RES = 2'h0;
    repeat (12) @(posedge SYS_CLK);
    #1;
    check(CFG_RDATA, CFG_RESET);
    check({6'h0, RX_TERMINATE, TIMEOUT_RUNNING}, 8'h00);
    @(posedge SYS_CLK) RESETN <= 1'b1;
    wr(8'hf2);
    run_to(8'h00, 16'h0017, 2'h0, 2, 1'b0, 1'b0, 1'b1);
    run_to(8'h02, 16'h0008, 2'h1, 1, 1'b0, 1'b0, 1'b1);
    run_to(8'h01, 16'h0008, 2'h2, 4, 1'b0, 1'b0, 1'b1);
    run_to(8'h03, 16'h0008, 2'h3, 1, 1'b0, 1'b0, 1'b1);
    run_to(8'h00, 16'h0008, 2'h0, 1, 1'b1, 1'b0, 1'b0);
    run_to(8'h08, 16'h0008, 2'h0, 1, 1'b0, 1'b1, 1'b0);
    run_to(8'h00, 16'h0008, 2'h0, 1, 1'b0, 1'b1, 1'b1);
    early(1'b0, 1'b0, 1'b1, 1'b1);
    early(1'b0, 1'b1, 1'b0, 1'b0);
    early(1'b1, 1'b1, 1'b0, 1'b1);
    early(1'b1, 1'b0, 1'b1, 1'b0);
    no_limit;
    end_of_test;
  end
endmodule // tb_rx_timeout_control
